/* File: cdd_pkg.sv */
// Shared constants and types of the clock distribution divider block.
// Assumes a single 125 MHz system clock; all source clocks arrive as pins.
package cdd_pkg;

	// ********************************************************************
	// Register indices (byte address is four times the index)
	// ********************************************************************
	localparam logic [9:0] CDD_IDX_CH0_COUNTS = 10'h190;
	localparam logic [9:0] CDD_IDX_CH0_BYPASS = 10'h191;
	localparam logic [9:0] CDD_IDX_CH0_ROUTE = 10'h192;
	localparam logic [9:0] CDD_IDX_CH1_COUNTS = 10'h193;
	localparam logic [9:0] CDD_IDX_CH1_BYPASS = 10'h194;
	localparam logic [9:0] CDD_IDX_CH1_ROUTE = 10'h195;
	localparam logic [9:0] CDD_IDX_CH2_COUNTS = 10'h196;
	localparam logic [9:0] CDD_IDX_CH2_BYPASS = 10'h197;
	localparam logic [9:0] CDD_IDX_CH2_ROUTE = 10'h198;
	localparam logic [9:0] CDD_IDX_PRESCALE = 10'h1e0;
	localparam logic [9:0] CDD_IDX_SOURCE = 10'h1e1;
	localparam logic [9:0] CDD_IDX_UPDATE = 10'h232;
	localparam logic [9:0] CDD_IDX_STATUS = 10'h240;

	// Per-channel index tables, built from the names above
	localparam logic [9:0] CDD_IDX_COUNTS [3] = '{CDD_IDX_CH0_COUNTS,
		CDD_IDX_CH1_COUNTS, CDD_IDX_CH2_COUNTS};
	localparam logic [9:0] CDD_IDX_BYPASS [3] = '{CDD_IDX_CH0_BYPASS,
		CDD_IDX_CH1_BYPASS, CDD_IDX_CH2_BYPASS};
	localparam logic [9:0] CDD_IDX_ROUTE [3] = '{CDD_IDX_CH0_ROUTE,
		CDD_IDX_CH1_ROUTE, CDD_IDX_CH2_ROUTE};

	// ********************************************************************
	// Field positions
	// ********************************************************************
	localparam int CDD_LOW_MSB = 7;
	localparam int CDD_LOW_LSB = 4;
	localparam int CDD_HIGH_MSB = 3;
	localparam int CDD_HIGH_LSB = 0;
	localparam int CDD_BYPASS_BIT = 7;
	localparam int CDD_DIRECT_BIT = 1;
	localparam int CDD_DUTY_CORRECT_DISABLE_BIT = 0;
	localparam int CDD_RATIO_MSB = 2;
	localparam int CDD_SRC_MSB = 1;
	localparam int CDD_UPDATE_BIT = 0;

	// ********************************************************************
	// Reset values
	// ********************************************************************
	localparam logic [7:0] CDD_RST_COUNTS = 8'h00;
	localparam logic [7:0] CDD_RST_BYPASS = 8'h00;
	localparam logic [7:0] CDD_RST_ROUTE = 8'h00;
	localparam logic [7:0] CDD_RST_PRESCALE = 8'h02;
	localparam logic [7:0] CDD_RST_SOURCE = 8'h00;

	// Prescaler ratio limits
	localparam logic [2:0] CDD_RATIO_MIN = 3'h2;
	localparam logic [2:0] CDD_RATIO_MAX = 3'h6;

	// Distribution source codes
	typedef enum logic [1:0] {
		CDD_SRC_EXT_PRE = 2'b00,
		CDD_SRC_EXT_DIRECT = 2'b01,
		CDD_SRC_OSC_PRE = 2'b10,
		CDD_SRC_FORBIDDEN = 2'b11
	} cdd_src_t;

	// Active channel settings
	typedef struct packed {
		logic [3:0] low;
		logic [3:0] high;
		logic bypass;
		logic direct;
		logic dcc_off;
	} cdd_chan_cfg_t;

	// A clock level with its edges, as seen on the system clock
	typedef struct packed {
		logic lvl;
		logic rise;
		logic fall;
	} cdd_edge_t;

endpackage

/* File: cdd_chan_div.sv */
// One channel divider driving one output pair.
// Assumes its input clock is given as a level plus edge pulses on clk_i.
module cdd_chan_div import cdd_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire cdd_chan_cfg_t cfg_i,
	input wire cdd_edge_t div_in_i,
	input wire logic byp_lvl_i,
	input wire logic byp_corr_lvl_i,
	input wire logic route_lvl_i,
	output logic pair_o
);

	// ********************************************************************
	// Half-cycle counter
	// ********************************************************************
	logic [6:0] cnt_reg; // Half cycles of the divider input
	logic [6:0] cnt_next;
	logic [6:0] total; // Half cycles in one output period, up to 64
	logic [6:0] high_len; // Half cycles spent high
	logic corr_prev_reg; // Corrected input level one clock ago
	logic half_tick; // Any edge of the clock being counted

	// Correction counts on the half-duty grid, else on the raw input;
	// an odd prescaler's raw edges are uneven and would skew the duty
	assign half_tick = cfg_i.dcc_off ? (div_in_i.rise | div_in_i.fall) :
		(byp_corr_lvl_i != corr_prev_reg);

	// Previous corrected level for edge finding
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			corr_prev_reg <= 1'b0;
		end else begin
			corr_prev_reg <= byp_corr_lvl_i;
		end
	end

	// Period and high time from the cycle fields
	always_comb begin
		// Each field stores one less than its cycle count
		// Ratio is high plus low plus two, 2 to 32
		total = 7'({2'b0, cfg_i.high} + {2'b0, cfg_i.low} + 6'h2) << 1;
		if (cfg_i.dcc_off) begin
			// High time over total gives the duty
			high_len = 7'({2'b0, cfg_i.high} + 6'h1) << 1;
		end else begin
			// Half the period, on a half-cycle grid
			high_len = 7'({2'b0, cfg_i.high} + {2'b0, cfg_i.low} + 6'h2);
		end
		cnt_next = cnt_reg;
		if (cnt_reg >= total) begin
			// Shorter period after an update: restart at once
			cnt_next = 7'h0;
		end else if (half_tick) begin
			// Counts only edges of the routed input clock
			cnt_next = (cnt_reg >= total - 7'h1) ? 7'h0 : cnt_reg + 7'h1;
		end
	end

	// Counter stands still while bypassed, as if powered down
	always_ff @(posedge clk_i) begin
		if (rst_i || cfg_i.bypass || cfg_i.direct) begin
			cnt_reg <= 7'h0;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	// ********************************************************************
	// Output selection
	// ********************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pair_o <= 1'b0;
		end else if (cfg_i.direct) begin
			pair_o <= route_lvl_i; // Prescaler input straight out
		end else if (cfg_i.bypass) begin
			// Divide by one, corrected or raw
			pair_o <= cfg_i.dcc_off ? byp_lvl_i : byp_corr_lvl_i;
		end else begin
			// High phase first from count zero
			pair_o <= (cnt_reg < high_len);
		end
	end

	// ********************************************************************
	// Checks
	// ********************************************************************
	property p_cnt_in_range;
		@(posedge clk_i) disable iff (rst_i)
		!cfg_i.bypass && !cfg_i.direct && $stable(cfg_i) |->
			cnt_reg < total;
	endproperty
	a_cnt_in_range: assert property (p_cnt_in_range)
		else $error("Divider count beyond period");

	property p_direct_follows;
		@(posedge clk_i) disable iff (rst_i)
		cfg_i.direct ##1 cfg_i.direct |-> pair_o == $past(route_lvl_i);
	endproperty
	a_direct_follows: assert property (p_direct_follows)
		else $error("Direct route does not follow source");

	property p_bypass_raw;
		@(posedge clk_i) disable iff (rst_i)
		(cfg_i.bypass && !cfg_i.direct && cfg_i.dcc_off) ##1
		(cfg_i.bypass && !cfg_i.direct && cfg_i.dcc_off)
		|-> pair_o == $past(byp_lvl_i);
	endproperty
	a_bypass_raw: assert property (p_bypass_raw)
		else $error("Bypassed output does not follow input");

	property p_bypass_idle;
		@(posedge clk_i) disable iff (rst_i)
		cfg_i.bypass ##1 cfg_i.bypass |-> cnt_reg == 7'h0;
	endproperty
	a_bypass_idle: assert property (p_bypass_idle)
		else $error("Divider runs while bypassed");

	property p_start_high;
		@(posedge clk_i) disable iff (rst_i)
		(!cfg_i.bypass && !cfg_i.direct && cnt_reg == 7'h0) ##1
		(!cfg_i.bypass && !cfg_i.direct) |-> pair_o;
	endproperty
	a_start_high: assert property (p_start_high)
		else $error("Period does not open high");

	c_divide_wrap: cover property (@(posedge clk_i) disable iff (rst_i)
		half_tick && cnt_reg == total - 7'h1 && !cfg_i.bypass);

endmodule

/* File: cdd_top.sv */
// Clock distribution divider path: source select, prescaler, three
// channel dividers and a classic Wishbone register slave.
// Assumes source clocks arrive as pins much slower than clk_i, so that
// each level is seen for several system clocks after synchronising.
//
// What this block does
// - Route bit sends prescaler input straight out
// - Code 00 external, 10 oscillator, both prescaled
// - Total division is prescaler times channel ratio
// - Prescaler divides source by two to six
// - Low field 7:4, high field 3:0
// - Bypass divides by one, divider stops
// - Correction on by default, disable bit each
// - Each field gives one more cycle
// - Channel ratio is high plus low plus two
// - Count cycles of routed divider input clock
// - Correction forces half duty, software sets fields
// - Uncorrected duty is high count over ratio
// - Bypassed prescaler duty depends on ratio, correction
// - Odd ratio corrected duty tracks source duty
// - Three channels, each drives one output pair
// - Code 01 skips prescaler, code 11 forbidden
// - Divider settings act only after update write
//
// The implementer's own choice: the Wishbone slave port.
module cdd_top import cdd_pkg::*; #(
	parameter int NUM_CH = 3 // Channels, one output pair each
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ext_clk_i,
	input wire logic osc_clk_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [11:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic [NUM_CH-1:0] clock_output_pairs_o
);

	// ********************************************************************
	// Pin synchronisers
	// ********************************************************************
	logic ext_s1_reg; // First stage, read only by the second
	logic ext_s2_reg;
	logic osc_s1_reg; // First stage, read only by the second
	logic osc_s2_reg;

	// Two flops on each source pin
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ext_s1_reg <= 1'b0;
			ext_s2_reg <= 1'b0;
			osc_s1_reg <= 1'b0;
			osc_s2_reg <= 1'b0;
		end else begin
			ext_s1_reg <= ext_clk_i;
			ext_s2_reg <= ext_s1_reg;
			osc_s1_reg <= osc_clk_i;
			osc_s2_reg <= osc_s1_reg;
		end
	end

	// ********************************************************************
	// Register file: staged copies seen by software
	// ********************************************************************
	logic [7:0] cnt_stg_reg [NUM_CH]; // Cycle count fields
	logic [7:0] byp_stg_reg [NUM_CH]; // Bypass control
	logic [7:0] rte_stg_reg [NUM_CH]; // Route and correction control
	logic [7:0] pre_stg_reg; // Prescaler ratio
	logic [7:0] src_stg_reg; // Source select
	logic [9:0] idx; // Word index of the access
	logic req; // New request this cycle
	logic wr_en; // Write strobe, low byte lane enabled
	logic upd_reg; // One-cycle update pulse

	assign idx = wb_adr_i[11:2];
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr_en = req && wb_we_i && wb_sel_i[0];

	// Ack one cycle after the request, then drop for one cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= req;
		end
	end

	// Per-channel staged registers
	genvar c;
	generate
		for (c = 0; c < NUM_CH; c++) begin : g_stage
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					cnt_stg_reg[c] <= CDD_RST_COUNTS;
					byp_stg_reg[c] <= CDD_RST_BYPASS;
					rte_stg_reg[c] <= CDD_RST_ROUTE;
				end else if (wr_en) begin
					// Consecutive register triplets per channel
					if (idx == CDD_IDX_COUNTS[c]) begin
						cnt_stg_reg[c] <= wb_dat_i[7:0];
					end
					if (idx == CDD_IDX_BYPASS[c]) begin
						byp_stg_reg[c] <= wb_dat_i[7:0];
					end
					if (idx == CDD_IDX_ROUTE[c]) begin
						rte_stg_reg[c] <= wb_dat_i[7:0];
					end
				end
			end
		end
	endgenerate

	// Global staged registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pre_stg_reg <= CDD_RST_PRESCALE;
			src_stg_reg <= CDD_RST_SOURCE;
		end else if (wr_en) begin
			if (idx == CDD_IDX_PRESCALE) begin
				pre_stg_reg <= wb_dat_i[7:0];
			end
			if (idx == CDD_IDX_SOURCE) begin
				src_stg_reg <= wb_dat_i[7:0];
			end
		end
	end

	// Update bit is self-clearing; a write of one fires one pulse
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			upd_reg <= 1'b0;
		end else begin
			upd_reg <= wr_en && idx == CDD_IDX_UPDATE &&
				wb_dat_i[CDD_UPDATE_BIT];
		end
	end

	// ********************************************************************
	// Active settings, loaded only by the update pulse
	// ********************************************************************
	cdd_chan_cfg_t cfg_reg [NUM_CH]; // What the dividers use
	logic [2:0] ratio_reg; // Active prescaler ratio
	cdd_src_t src_reg; // Active source code
	logic [2:0] ratio_fld; // Staged ratio, clamped to 2..6

	// Out-of-range codes clamp rather than stall the prescaler
	always_comb begin
		ratio_fld = pre_stg_reg[CDD_RATIO_MSB:0];
		if (ratio_fld < CDD_RATIO_MIN) begin
			ratio_fld = CDD_RATIO_MIN;
		end else if (ratio_fld > CDD_RATIO_MAX) begin
			ratio_fld = CDD_RATIO_MAX;
		end
	end

	generate
		for (c = 0; c < NUM_CH; c++) begin : g_active
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					cfg_reg[c] <= '{low: CDD_RST_COUNTS[CDD_LOW_MSB:CDD_LOW_LSB],
						high: CDD_RST_COUNTS[CDD_HIGH_MSB:CDD_HIGH_LSB],
						bypass: CDD_RST_BYPASS[CDD_BYPASS_BIT],
						direct: CDD_RST_ROUTE[CDD_DIRECT_BIT],
						dcc_off: CDD_RST_ROUTE[CDD_DUTY_CORRECT_DISABLE_BIT]};
				end else if (upd_reg) begin
					// Copy staged fields at update only
					cfg_reg[c].low <= cnt_stg_reg[c][CDD_LOW_MSB:CDD_LOW_LSB];
					cfg_reg[c].high <=
						cnt_stg_reg[c][CDD_HIGH_MSB:CDD_HIGH_LSB];
					cfg_reg[c].bypass <= byp_stg_reg[c][CDD_BYPASS_BIT];
					cfg_reg[c].direct <= rte_stg_reg[c][CDD_DIRECT_BIT];
					cfg_reg[c].dcc_off <= rte_stg_reg[c][CDD_DUTY_CORRECT_DISABLE_BIT];
				end
			end
		end
	endgenerate

	// Global active settings
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ratio_reg <= CDD_RST_PRESCALE[CDD_RATIO_MSB:0];
			src_reg <= cdd_src_t'(CDD_RST_SOURCE[CDD_SRC_MSB:0]);
		end else if (upd_reg) begin
			ratio_reg <= ratio_fld;
			src_reg <= cdd_src_t'(src_stg_reg[CDD_SRC_MSB:0]);
		end
	end

	// ********************************************************************
	// Source select and prescaler
	// ********************************************************************
	logic src_lvl; // Prescaler input level
	logic src_prev_reg; // Source level one clock ago
	logic [3:0] pre_cnt_reg; // Half cycles of the source
	logic [3:0] pre_half; // Half cycles per prescaler period
	logic pre_lvl_reg; // Prescaler output, uncorrected
	logic pre_corr_reg; // Prescaler output, half duty
	logic src_tick; // Any source edge

	// Pick the source; the forbidden code gives no clock
	always_comb begin
		case (src_reg)
			CDD_SRC_EXT_PRE: src_lvl = ext_s2_reg;
			CDD_SRC_EXT_DIRECT: src_lvl = ext_s2_reg;
			CDD_SRC_OSC_PRE: src_lvl = osc_s2_reg;
			default: src_lvl = 1'b0;
		endcase
	end

	assign src_tick = src_lvl != src_prev_reg;
	assign pre_half = {ratio_reg, 1'b0};

	// Previous source level for edge finding
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			src_prev_reg <= 1'b0;
		end else begin
			src_prev_reg <= src_lvl;
		end
	end

	// Count source half cycles over one prescaler period
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pre_cnt_reg <= 4'h0;
		end else if (src_tick || pre_cnt_reg >= pre_half) begin
			// A smaller ratio restarts the count at once
			pre_cnt_reg <= (pre_cnt_reg >= pre_half - 4'h1) ? 4'h0 :
				pre_cnt_reg + 4'h1;
		end
	end

	// Raw output high for half the even part of the ratio; corrected output for half the period
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pre_lvl_reg <= 1'b0;
			pre_corr_reg <= 1'b0;
		end else begin
			// Odd ratios give 1 of 3 or 2 of 5 cycles high
			pre_lvl_reg <= pre_cnt_reg < {ratio_reg[2:1], 2'b00} >> 1;
			// Half-cycle grid keeps the source duty in the result
			pre_corr_reg <= pre_cnt_reg < {1'b0, ratio_reg};
		end
	end

	// ********************************************************************
	// Divider input clock
	// ********************************************************************
	logic div_lvl; // Clock at the channel divider inputs
	logic div_prev_reg;
	logic byp_corr_lvl; // Corrected clock for bypassed channels
	cdd_edge_t div_in; // Divider input level with edges

	// Prescaler output, or external clock when code 01
	always_comb begin
		if (src_reg == CDD_SRC_EXT_DIRECT) begin
			div_lvl = ext_s2_reg;
			byp_corr_lvl = ext_s2_reg; // Same as input duty
		end else begin
			div_lvl = pre_lvl_reg; // Channel counts scale it
			byp_corr_lvl = pre_corr_reg;
		end
	end

	// Previous divider input for edge finding
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div_prev_reg <= 1'b0;
		end else begin
			div_prev_reg <= div_lvl;
		end
	end

	assign div_in = '{lvl: div_lvl, rise: div_lvl && !div_prev_reg,
		fall: !div_lvl && div_prev_reg};

	// ********************************************************************
	// Channel dividers, one per output pair
	// ********************************************************************
	generate
		for (c = 0; c < NUM_CH; c++) begin : g_chan
			// Route uses the prescaler input; software must pick 00 or 10
			cdd_chan_div u_div (
				.clk_i(clk_i),
				.rst_i(rst_i),
				.cfg_i(cfg_reg[c]),
				.div_in_i(div_in),
				.byp_lvl_i(div_lvl),
				.byp_corr_lvl_i(byp_corr_lvl),
				.route_lvl_i(src_lvl),
				.pair_o(clock_output_pairs_o[c])
			);
		end
	endgenerate

	// ********************************************************************
	// Read path
	// ********************************************************************
	logic [7:0] rd_byte; // Selected register, low byte lane

	// Reads return staged values; status shows live levels
	always_comb begin
		rd_byte = 8'h00; // Unmapped reads give zero
		for (int i = 0; i < NUM_CH; i++) begin
			if (idx == CDD_IDX_COUNTS[i]) begin
				rd_byte = cnt_stg_reg[i];
			end
			if (idx == CDD_IDX_BYPASS[i]) begin
				rd_byte = byp_stg_reg[i];
			end
			if (idx == CDD_IDX_ROUTE[i]) begin
				rd_byte = rte_stg_reg[i];
			end
		end
		if (idx == CDD_IDX_PRESCALE) begin
			rd_byte = pre_stg_reg;
		end
		if (idx == CDD_IDX_SOURCE) begin
			rd_byte = src_stg_reg;
		end
		if (idx == CDD_IDX_STATUS) begin
			rd_byte = 8'({pre_lvl_reg, clock_output_pairs_o});
		end
	end

	// Read data registered with the ack
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0;
		end else if (req) begin
			wb_dat_o <= {24'h0, rd_byte};
		end
	end

	// ********************************************************************
	// Checks
	// ********************************************************************
	property p_ack_next;
		@(posedge clk_i) disable iff (rst_i)
		req |=> wb_ack_o ##1 !wb_ack_o;
	endproperty
	a_ack_next: assert property (p_ack_next)
		else $error("Ack not one cycle after request");

	property p_update_load;
		@(posedge clk_i) disable iff (rst_i)
		upd_reg |=> cfg_reg[0].high == $past(cnt_stg_reg[0][3:0]) &&
			cfg_reg[0].bypass == $past(byp_stg_reg[0][7]);
	endproperty
	a_update_load: assert property (p_update_load)
		else $error("Update did not load settings");

	property p_no_update_hold;
		@(posedge clk_i) disable iff (rst_i)
		!upd_reg |=> $stable(ratio_reg) && $stable(src_reg);
	endproperty
	a_no_update_hold: assert property (p_no_update_hold)
		else $error("Settings changed without update");

	property p_ratio_range;
		@(posedge clk_i) disable iff (rst_i)
		ratio_reg >= CDD_RATIO_MIN && ratio_reg <= CDD_RATIO_MAX &&
			(!$stable(ratio_reg) || pre_cnt_reg < pre_half);
	endproperty
	a_ratio_range: assert property (p_ratio_range)
		else $error("Prescaler out of range");

	property p_forbidden_still;
		@(posedge clk_i) disable iff (rst_i)
		src_reg == CDD_SRC_FORBIDDEN |-> !src_lvl;
	endproperty
	a_forbidden_still: assert property (p_forbidden_still)
		else $error("Forbidden source passes a clock");

	property p_osc_prescaled;
		@(posedge clk_i) disable iff (rst_i)
		src_reg == CDD_SRC_OSC_PRE |-> src_lvl == osc_s2_reg &&
			div_lvl == pre_lvl_reg;
	endproperty
	a_osc_prescaled: assert property (p_osc_prescaled)
		else $error("Oscillator bypasses prescaler");

	c_update: cover property (@(posedge clk_i) disable iff (rst_i) upd_reg);
	c_osc_run: cover property (@(posedge clk_i) disable iff (rst_i)
		src_reg == CDD_SRC_OSC_PRE && div_in.rise);
	c_read: cover property (@(posedge clk_i) disable iff (rst_i)
		req && !wb_we_i && idx == CDD_IDX_STATUS);

endmodule

/* File: cdd_src_model.sv */
// Source model: external clock pin and internal oscillator.
// Assumes clk_i is the system clock; source edges follow its edges.
module cdd_src_model #(
	parameter int EXT_HALF = 5, // External half period, system clocks
	parameter int OSC_HALF = 7 // Oscillator half period, system clocks
) (
	input wire logic clk_i,
	output logic ext_clk_o,
	output logic osc_clk_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int ext_cnt = 0; // Cycles into the external half period
	int osc_cnt = 0; // Cycles into the oscillator half period
	initial ext_clk_o = 1'b0;
	initial osc_clk_o = 1'b0;
	// Both run free at 50% duty; half periods of four or more system
	// clocks keep the divider input inside its rate limit
	always @(posedge clk_i) begin
		ext_cnt <= (ext_cnt == EXT_HALF - 1) ? 0 : ext_cnt + 1;
		if (ext_cnt == EXT_HALF - 1) begin
			ext_clk_o <= ~ext_clk_o;
		end
		osc_cnt <= (osc_cnt == OSC_HALF - 1) ? 0 : osc_cnt + 1;
		if (osc_cnt == OSC_HALF - 1) begin
			osc_clk_o <= ~osc_clk_o;
		end
	end
endmodule

/* File: clock_distribution_dividers_test.sv */
// Self-checking bench of the divider path, times in system clocks.
// Assumes source model edges track clk, so output times are exact.
module clock_distribution_dividers_test;
	timeunit 1ns;
	timeprecision 1ps;
	import cdd_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1; // Synchronous reset, held at start
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [11:0] adr = 12'h000;
	logic [31:0] dat_w = 32'h0;
	logic [31:0] dat_r;
	logic ack;
	logic [2:0] pairs; // One level per output pair
	logic ext;
	logic osc;
	int err_count = 0;
	int total_checks = 0;
	int ch, n, m, p, h, q; // Scenario values and expectations
	logic [31:0] seed = 32'h96a35428;
	initial forever #4 clk = ~clk;
	cdd_src_model #(.EXT_HALF(5), .OSC_HALF(7)) i_cdd_src_model (
		.clk_i(clk), .ext_clk_o(ext), .osc_clk_o(osc));
	cdd_top #(.NUM_CH(3)) i_cdd_top (.clk_i(clk), .rst_i(rst),
		.ext_clk_i(ext), .osc_clk_i(osc), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat_w),
		.wb_dat_o(dat_r), .wb_ack_o(ack), .clock_output_pairs_o(pairs));
	// ****************************************
	// Helpers
	// ****************************************
	// Xorshift source of scenario values
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	// Classic cycle; wait for ack is bounded, a hang counts as error
	task automatic wb(input logic w, input logic [9:0] idx,
		input logic [7:0] d, output logic [31:0] rq);
		int k;
		k = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {idx, 2'b00};
		dat_w <= {24'h0, d};
		do begin
			@(posedge clk);
			k++;
		end while (ack !== 1'b1 && k < 50);
		if (k >= 50) err_count++;
		rq = dat_r;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [9:0] idx, input logic [7:0] d);
		logic [31:0] rq;
		wb(1'b1, idx, d, rq);
	endtask
	task automatic rd(input logic [9:0] idx, input logic [7:0] e);
		logic [31:0] rq;
		wb(1'b0, idx, 8'h00, rq);
		check(rq, {24'h0, e});
	endtask
	// Cycles until the pair shows the given level
	task automatic wait_lvl(input int c, input logic lvl, output int k);
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pairs[c] !== lvl && k < 5000);
	endtask
	// Skips one edge pair so the first, irregular period is ignored
	task automatic meas(input int c, input int hi, input int per);
		int a, b;
		wait_lvl(c, 1'b1, a);
		wait_lvl(c, 1'b0, a);
		wait_lvl(c, 1'b1, a);
		wait_lvl(c, 1'b0, a);
		wait_lvl(c, 1'b1, b);
		check(32'(a), 32'(hi));
		check(32'(a + b), 32'(per));
	endtask
	task automatic run(input int c, nn, mm, byp, dir, off, r, src, hi, per);
		wr(CDD_IDX_COUNTS[c], {mm[3:0], nn[3:0]});
		wr(CDD_IDX_BYPASS[c], byp ? 8'h80 : 8'h00);
		wr(CDD_IDX_ROUTE[c], {6'h0, dir[0], off[0]});
		wr(CDD_IDX_PRESCALE, r[7:0]);
		wr(CDD_IDX_SOURCE, src[7:0]);
		wr(CDD_IDX_UPDATE, 8'h01);
		meas(c, hi, per);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(CDD_IDX_PRESCALE, CDD_RST_PRESCALE);
		rd(CDD_IDX_CH0_ROUTE, CDD_RST_ROUTE);
		rd(CDD_IDX_SOURCE, CDD_RST_SOURCE);
		rd(10'h100, 8'h00);
		// Every prescaler ratio, random fields and channel
		for (int r = 2; r <= 6; r++) begin
			ch = int'(rnd() % 3);
			n = int'(rnd() % 16);
			m = int'(rnd() % 8);
			p = 10 * r;
			h = (n + 1) * p;
			q = (n + m + 2) * p;
			run(ch, n, m, 0, 0, 1, r, 0, h, q);
			rd(CDD_IDX_COUNTS[ch], 8'({m[3:0], n[3:0]}));
		end
		run(1, 2, 3, 0, 0, 0, 3, 0, 105, 210);
		run(2, 4, 1, 0, 0, 1, 2, 0, 100, 140);
		run(0, 0, 0, 1, 0, 1, 3, 0, 10, 30);
		run(0, 0, 0, 1, 0, 1, 5, 0, 20, 50);
		run(0, 0, 0, 1, 0, 0, 3, 0, 15, 30);
		run(1, 0, 0, 0, 1, 1, 2, 0, 5, 10);
		wr(CDD_IDX_CH1_ROUTE, 8'h00); // No direct route under code 01
		run(2, 1, 1, 0, 0, 1, 4, 1, 20, 40);
		run(0, 0, 0, 0, 0, 1, 2, 2, 28, 56);
		wr(CDD_IDX_CH0_COUNTS, 8'hff);
		meas(0, 28, 56);
		rd(CDD_IDX_CH0_COUNTS, 8'hff);
		tally_and_finish();
	end
	// Watchdog well above the longest expected run
	initial begin
		repeat (95000) @(posedge clk);
		err_count++;
		tally_and_finish();
	end
endmodule
